// ==== rtl/hpp_port.sv ====
// host parallel port: 16-bit multiplexed host side, wishbone cpu side,
// single-outstanding memory master toward the on-chip interconnect.
// assumes clock_i is the peripheral clock and host data/controls stay
// stable while the strobe is active.
// Functional notes
// - each access is two 16-bit halves assembled into one 32-bit word
// - an address from the host is captured into a 32-bit address register
// - separate read and write address registers, optionally acting as one
// - ready is withheld while internal resources are busy
// - write data is held in a 32-bit register until stored to memory
// - read data is held until the host may complete the transfer
// - autoincrement bursts use separate eight-word read and write fifos
// - fixed-address accesses use only one fifo location
// - cpu raises host interrupt, clears host request, monitors the port
// - host configures, raises cpu interrupt, clears the cpu request
// - control and address registers are reachable by cpu and host
// - host is master and may be asynchronous to the internal clock
// - port clock is the main pll output divided by six
// - read prefetch into the fifo is under software control
// - a register sets address/control ownership and fifo timeout
// - host accesses are routed to any on-chip resource by address
// - access type is latched when the internal strobe goes active
// - ready low lets the host finish; high holds it off
`timescale 1ns/10ps
`include "hpp_consts.svh"
module hpp_port
  import hpp_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        host_cs_n_i,
  input  wire logic        host_ds_n_i,
  input  wire logic        host_rw_i,
  input  wire logic [1:0]  access_type_select_i,
  input  wire logic        halfword_select_i,
  input  wire logic [15:0] host_data_i,
  output logic      [15:0] host_data_o,
  output logic             host_data_oe_o,
  output logic             port_ready_out_o,
  output logic             host_int_n_o,
  output logic             cpu_int_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_addr_o,
  output logic      [31:0] mem_wdata_o,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic        mem_ack_i
);

  // clock_i is the peripheral clock, main pll divided by HPP_PLL_DIV
  localparam int PLL_DIV = `HPP_PLL_DIV;

  function automatic logic [15:0] hpp_half(input logic [31:0] w,
                                           input logic        hi);
    hpp_half = hi ? w[31:16] : w[15:0];
  endfunction

  function automatic logic [31:0] hpp_bytes(input logic [31:0] old,
                                            input logic [31:0] din,
                                            input logic [3:0]  sel);
    hpp_bytes = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        hpp_bytes[i*8 +: 8] = din[i*8 +: 8];
  endfunction

  logic        cs_s1_r, cs_s2_r, ds_s1_r, ds_s2_r, strb_q_r;
  logic        strb_now, st_rise, st_fall;
  hpp_hst_t    hst_r, hst_nxt;
  logic [1:0]  at_r, at_nxt;
  logic        rw_r, rw_nxt, hw_r, hw_nxt;
  logic        rdy_r, rdy_nxt, oe_r, oe_nxt;
  logic [15:0] dout_r, dout_nxt, lo_r, lo_nxt;
  logic        hint_r, hint_nxt, cint_r, cint_nxt;
  logic        dual_r, dual_nxt, asel_r, asel_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [31:0] waddr_r, waddr_nxt, raddr_r, raddr_nxt;
  logic [32:0] wf_mem [0:7];
  logic [31:0] rf_mem [0:7];
  logic [2:0]  wf_wp_r, wf_wp_nxt, wf_rp_r, wf_rp_nxt;
  logic [2:0]  rf_wp_r, rf_wp_nxt, rf_rp_r, rf_rp_nxt;
  logic [3:0]  wf_cnt_r, wf_cnt_nxt, rf_cnt_r, rf_cnt_nxt;
  logic        wf_push, wf_pop, rf_push, rf_pop, rf_flush;
  logic [32:0] wf_din;
  hpp_mem_t    ms_r, ms_nxt;
  logic        req_r, req_nxt, mwe_r, mwe_nxt, minc_r, minc_nxt;
  logic [31:0] maddr_r, maddr_nxt, mwd_r, mwd_nxt;
  logic        fetch_r, fetch_nxt, finc_r, finc_nxt, pref_r, pref_nxt;
  logic [7:0]  to_cnt_r, to_cnt_nxt;
  logic        ack_r, ack_nxt, intn_r;
  logic [31:0] wbd_r, wbd_nxt, ctrl_word, src_word;
  logic        wb_hit, wb_wr, is_data, hs_ok, cpu_lock, addr_hold;

  // first stage feeds only the second; host timing is unrelated to ours
  always_ff @(posedge clock_i)
  begin
    cs_s1_r <= host_cs_n_i;
    cs_s2_r <= cs_s1_r;
    ds_s1_r <= host_ds_n_i;
    ds_s2_r <= ds_s1_r;
    strb_q_r <= sys_rst_i ? 1'b0 : strb_now;
  end

  // internal strobe and its edges, all from the second stage
  assign strb_now = ~cs_s2_r & ~ds_s2_r;
  assign st_rise  = strb_now & ~strb_q_r;
  assign st_fall  = ~strb_now & strb_q_r;
  assign is_data  = (at_r == `HPP_AT_INC) | (at_r == `HPP_AT_FIX);
  assign cpu_lock = cfg_r[`HPP_CFG_LOCK];
  assign wb_hit   = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr    = wb_hit & wb_we_i;
  // no read may start while the host loads an address, or its ack
  // would bump the half that the host has just written
  assign addr_hold = (hst_r != HS_IDLE) & (at_r == `HPP_AT_ADDR) & ~rw_r;

  // control word as seen by both sides, status bits are live
  assign ctrl_word = {25'h0, req_r, rf_cnt_r == 4'h0, wf_cnt_r == 4'h0,
                      asel_r, dual_r, cint_r, hint_r};

  // word the host reads for the latched access type
  always_comb
  begin
    case (at_r)
      `HPP_AT_CTRL: src_word = ctrl_word;
      `HPP_AT_ADDR: src_word = (dual_r & asel_r) ? raddr_r : waddr_r;
      default:      src_word = rf_mem[rf_rp_r];
    endcase
  end

  // resource check before ready is given for the current half
  always_comb
  begin
    hs_ok = 1'b1;
    if (is_data & rw_r)
      hs_ok = (rf_cnt_r != 4'h0);
    else if (is_data & hw_r)
      hs_ok = (at_r == `HPP_AT_INC) ? (wf_cnt_r != `HPP_FIFO_DEPTH)
                                    : (wf_cnt_r == 4'h0);
    else if ((at_r == `HPP_AT_ADDR) & ~rw_r)
      hs_ok = (wf_cnt_r == 4'h0) & ~req_r;
  end

  // host side, registers, fifo pointers and memory engine in one step
  always_comb
  begin
    hst_nxt = hst_r;
    at_nxt = at_r;
    rw_nxt = rw_r;
    hw_nxt = hw_r;
    rdy_nxt = rdy_r;
    oe_nxt = oe_r;
    dout_nxt = dout_r;
    lo_nxt = lo_r;
    hint_nxt = hint_r;
    cint_nxt = cint_r;
    dual_nxt = dual_r;
    asel_nxt = asel_r;
    cfg_nxt = cfg_r;
    waddr_nxt = waddr_r;
    raddr_nxt = raddr_r;
    wf_push = 1'b0;
    wf_pop = 1'b0;
    rf_push = 1'b0;
    rf_pop = 1'b0;
    rf_flush = 1'b0;
    wf_din = {at_r == `HPP_AT_INC, host_data_i, lo_r};
    ms_nxt = ms_r;
    req_nxt = req_r;
    mwe_nxt = mwe_r;
    minc_nxt = minc_r;
    maddr_nxt = maddr_r;
    mwd_nxt = mwd_r;
    fetch_nxt = fetch_r;
    finc_nxt = finc_r;
    pref_nxt = pref_r;
    to_cnt_nxt = to_cnt_r;
    ack_nxt = wb_hit;
    wbd_nxt = 32'h0;
    // memory engine: retire, then issue; writes drain before reads
    case (ms_r)
      MS_IDLE:
      begin
        if (wf_cnt_r != 4'h0)
        begin
          req_nxt = 1'b1;
          mwe_nxt = 1'b1;
          maddr_nxt = waddr_r;
          mwd_nxt = wf_mem[wf_rp_r][31:0];
          minc_nxt = wf_mem[wf_rp_r][32];
          wf_pop = 1'b1;
          ms_nxt = MS_BUSY;
        end
        else if ((fetch_r | (pref_r & (rf_cnt_r != `HPP_FIFO_DEPTH)))
                 & ~addr_hold)
        begin
          req_nxt = 1'b1;
          mwe_nxt = 1'b0;
          maddr_nxt = raddr_r;
          minc_nxt = fetch_r ? finc_r : 1'b1;
          fetch_nxt = 1'b0;
          ms_nxt = MS_BUSY;
        end
      end
      MS_BUSY:
      begin
        if (mem_ack_i)
        begin
          req_nxt = 1'b0;
          ms_nxt = MS_IDLE;
          rf_push = ~mwe_r;
          // single mode bumps both address registers together
          if (minc_r & (mwe_r | ~dual_r))
            waddr_nxt = waddr_r + `HPP_ADDR_STEP;
          if (minc_r & (~mwe_r | ~dual_r))
            raddr_nxt = raddr_r + `HPP_ADDR_STEP;
        end
      end
      default: ms_nxt = MS_IDLE;
    endcase
    // host strobe sequence
    case (hst_r)
      HS_IDLE:
      begin
        if (st_rise)
        begin
          at_nxt = access_type_select_i;
          rw_nxt = host_rw_i;
          hw_nxt = halfword_select_i;
          rdy_nxt = 1'b1;
          hst_nxt = HS_WAIT;
        end
      end
      HS_WAIT:
      begin
        if (~strb_now)
        begin
          rdy_nxt = 1'b0;
          hst_nxt = HS_IDLE;
        end
        else if (hs_ok)
        begin
          rdy_nxt = 1'b0;
          oe_nxt = rw_r;
          dout_nxt = hpp_half(src_word, hw_r);
          hst_nxt = HS_ACT;
        end
        // one demand fetch per miss; raising it again would fetch twice
        else if (is_data & rw_r & ~hw_r & ~req_r & ~fetch_r & ~pref_r)
        begin
          fetch_nxt = 1'b1;
          finc_nxt = (at_r == `HPP_AT_INC);
        end
      end
      HS_ACT:
      begin
        if (st_fall)
        begin
          oe_nxt = 1'b0;
          hst_nxt = HS_IDLE;
          if (rw_r & is_data & hw_r)
          begin
            rf_pop = 1'b1;
            pref_nxt = (at_r == `HPP_AT_INC) & cfg_r[`HPP_CFG_PREF];
          end
          else if (~rw_r & is_data)
          begin
            if (hw_r)
              wf_push = 1'b1;
            else
              lo_nxt = host_data_i;
          end
          else if (~rw_r & (at_r == `HPP_AT_ADDR) & ~cpu_lock)
          begin
            rf_flush = 1'b1;
            pref_nxt = 1'b0;
            // aligned byte address expected from the host
            if (~dual_r | ~asel_r)
              waddr_nxt[hw_r*16 +: 16] = host_data_i;
            if (~dual_r | asel_r)
              raddr_nxt[hw_r*16 +: 16] = host_data_i;
          end
          else if (~rw_r & (at_r == `HPP_AT_CTRL) & ~hw_r)
          begin
            if (host_data_i[`HPP_C_HINT])
              hint_nxt = 1'b0;
            if (~cpu_lock)
            begin
              dual_nxt = host_data_i[`HPP_C_DUAL];
              asel_nxt = host_data_i[`HPP_C_ASEL];
            end
          end
        end
      end
      default: hst_nxt = HS_IDLE;
    endcase
    // cpu side register access over wishbone
    case (wb_adr_i)
      `HPP_OFS_CTRL:
      begin
        wbd_nxt = ctrl_word;
        if (wb_wr & wb_sel_i[0])
        begin
          if (wb_dat_i[`HPP_C_CINT])
            cint_nxt = 1'b0;
          dual_nxt = wb_dat_i[`HPP_C_DUAL];
          asel_nxt = wb_dat_i[`HPP_C_ASEL];
        end
      end
      `HPP_OFS_WADDR:
      begin
        wbd_nxt = waddr_r;
        if (wb_wr)
          waddr_nxt = hpp_bytes(waddr_r, wb_dat_i, wb_sel_i);
      end
      `HPP_OFS_RADDR:
      begin
        wbd_nxt = raddr_r;
        if (wb_wr)
          raddr_nxt = hpp_bytes(raddr_r, wb_dat_i, wb_sel_i);
      end
      `HPP_OFS_CFG:
      begin
        wbd_nxt = {16'h0, cfg_r};
        if (wb_wr)
          cfg_nxt = 16'(hpp_bytes({16'h0, cfg_r}, wb_dat_i, wb_sel_i));
      end
      default: wbd_nxt = 32'h0;
    endcase
    // interrupt sets come last so a same-cycle clear never hides one
    if (wb_wr & (wb_adr_i == `HPP_OFS_CTRL) & wb_sel_i[0]
        & wb_dat_i[`HPP_C_HINT])
      hint_nxt = 1'b1;
    if (st_fall & (hst_r == HS_ACT) & ~rw_r & (at_r == `HPP_AT_CTRL)
        & ~hw_r & host_data_i[`HPP_C_CINT])
      cint_nxt = 1'b1;
    // stale prefetched words are dropped after a quiet spell
    if (st_rise | (rf_cnt_r == 4'h0) | (cfg_r[15:8] == 8'h00))
      to_cnt_nxt = 8'h00;
    else if (to_cnt_r == cfg_r[15:8])
    begin
      rf_flush = 1'b1;
      pref_nxt = 1'b0;
      to_cnt_nxt = 8'h00;
    end
    else
      to_cnt_nxt = to_cnt_r + 8'h01;
    // fifo pointers; a flush empties the read side but keeps a same-cycle push, and wins over a pop
    wf_wp_nxt = wf_wp_r + {2'b00, wf_push};
    wf_rp_nxt = wf_rp_r + {2'b00, wf_pop};
    wf_cnt_nxt = wf_cnt_r + {3'b000, wf_push} - {3'b000, wf_pop};
    rf_wp_nxt = rf_wp_r + {2'b00, rf_push};
    if (rf_flush)
    begin
      rf_rp_nxt = rf_wp_r;
      rf_cnt_nxt = {3'b000, rf_push};
    end
    else
    begin
      rf_rp_nxt = rf_rp_r + {2'b00, rf_pop};
      rf_cnt_nxt = rf_cnt_r + {3'b000, rf_push} - {3'b000, rf_pop};
    end
  end

  // state registers; synchronous reset to idle and empty
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      hst_r <= HS_IDLE;
      ms_r <= MS_IDLE;
      {at_r, rw_r, hw_r, rdy_r, oe_r, dout_r, lo_r} <= '0;
      {hint_r, cint_r, dual_r, asel_r, intn_r} <= 5'h01;
      cfg_r <= `HPP_CFG_RST;
      {waddr_r, raddr_r} <= '0;
      {wf_wp_r, wf_rp_r, rf_wp_r, rf_rp_r, wf_cnt_r, rf_cnt_r} <= '0;
      {req_r, mwe_r, minc_r, maddr_r, mwd_r} <= '0;
      {fetch_r, finc_r, pref_r, to_cnt_r, ack_r, wbd_r} <= '0;
    end
    else
    begin
      hst_r <= hst_nxt;
      ms_r <= ms_nxt;
      {at_r, rw_r, hw_r} <= {at_nxt, rw_nxt, hw_nxt};
      {rdy_r, oe_r, dout_r, lo_r} <= {rdy_nxt, oe_nxt, dout_nxt, lo_nxt};
      {hint_r, cint_r} <= {hint_nxt, cint_nxt};
      {dual_r, asel_r, cfg_r} <= {dual_nxt, asel_nxt, cfg_nxt};
      intn_r <= ~hint_nxt; // pin is the inverse of the flag
      {waddr_r, raddr_r} <= {waddr_nxt, raddr_nxt};
      {wf_wp_r, wf_rp_r, wf_cnt_r} <= {wf_wp_nxt, wf_rp_nxt, wf_cnt_nxt};
      {rf_wp_r, rf_rp_r, rf_cnt_r} <= {rf_wp_nxt, rf_rp_nxt, rf_cnt_nxt};
      {req_r, mwe_r, minc_r} <= {req_nxt, mwe_nxt, minc_nxt};
      {maddr_r, mwd_r} <= {maddr_nxt, mwd_nxt};
      {fetch_r, finc_r, pref_r} <= {fetch_nxt, finc_nxt, pref_nxt};
      {to_cnt_r, ack_r, wbd_r} <= {to_cnt_nxt, ack_nxt, wbd_nxt};
    end
  end

  // fifo storage, no reset needed since counts gate every read
  always_ff @(posedge clock_i)
  begin
    if (wf_push)
      wf_mem[wf_wp_r] <= wf_din;
    if (rf_push)
      rf_mem[rf_wp_r] <= mem_rdata_i;
  end

  // every output straight from a flip-flop
  assign host_data_o      = dout_r;
  assign host_data_oe_o   = oe_r;
  assign port_ready_out_o = rdy_r;
  assign host_int_n_o     = intn_r;
  assign cpu_int_o        = cint_r;
  assign wb_dat_o         = wbd_r;
  assign wb_ack_o         = ack_r;
  assign mem_req_o        = req_r;
  assign mem_we_o         = mwe_r;
  assign mem_addr_o       = maddr_r;
  assign mem_wdata_o      = mwd_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_wb_ack;
    wb_hit |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("wb ack");
  property p_hold_off;
    (hst_r == HS_IDLE) && st_rise |=> port_ready_out_o;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("rdy");
  property p_busy_wait;
    (hst_r == HS_WAIT) && !hs_ok && strb_now |=> port_ready_out_o;
  endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("busy");
  property p_fifo_cap;
    wf_cnt_r <= `HPP_FIFO_DEPTH && rf_cnt_r <= `HPP_FIFO_DEPTH;
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("fifo");
  property p_fix_one;
    wf_push && !wf_din[32] |-> wf_cnt_r == 4'h0;
  endproperty
  a_fix_one: assert property (p_fix_one) else $error("fix");
  property p_pair;
    wf_push |-> hw_r && !rw_r && is_data && hst_r == HS_ACT;
  endproperty
  a_pair: assert property (p_pair) else $error("pair");
  property p_set_wins;
    wb_wr && wb_adr_i == `HPP_OFS_CTRL && wb_sel_i[0]
      && wb_dat_i[`HPP_C_HINT] |=> !host_int_n_o && hint_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("hint");
  property p_latch;
    (hst_r == HS_IDLE) && st_rise
      |=> at_r == $past(access_type_select_i)
          && hw_r == $past(halfword_select_i)
          && rw_r == $past(host_rw_i);
  endproperty
  a_latch: assert property (p_latch) else $error("latch");
  property p_mem_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("mem");

  c_wf_full: cover property (wf_cnt_r == `HPP_FIFO_DEPTH);
  c_prefetch: cover property (pref_r && mem_req_o && !mem_we_o);
  c_timeout: cover property (rf_flush && rf_cnt_r != 4'h0);
endmodule

// ==== rtl/hpp_consts.svh ====
// constants for the host parallel port: offsets, fields, resets, counts
// assumes inclusion by bare name from the port module and the testbench
`ifndef HPP_CONSTS_SVH
`define HPP_CONSTS_SVH
`define HPP_PLL_DIV      6
`define HPP_OFS_CTRL     8'h00
`define HPP_OFS_WADDR    8'h04
`define HPP_OFS_RADDR    8'h08
`define HPP_OFS_CFG      8'h0C
`define HPP_C_HINT       0
`define HPP_C_CINT       1
`define HPP_C_DUAL       2
`define HPP_C_ASEL       3
`define HPP_C_WEMPTY     4
`define HPP_C_REMPTY     5
`define HPP_C_BUSY       6
`define HPP_CFG_PREF     0
`define HPP_CFG_LOCK     1
`define HPP_CFG_TO_LSB   8
`define HPP_CFG_RST      16'hFF00
`define HPP_AT_CTRL      2'h0
`define HPP_AT_INC       2'h1
`define HPP_AT_ADDR      2'h2
`define HPP_AT_FIX       2'h3
`define HPP_FIFO_DEPTH   4'h8
`define HPP_ADDR_STEP    32'h0000_0004
`endif

// ==== rtl/hpp_pkg.sv ====
// types for the host parallel port
// assumes nothing beyond the constants header
package hpp_pkg;
  typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_ACT} hpp_hst_t;
  typedef enum logic [0:0] {MS_IDLE, MS_BUSY} hpp_mem_t;
endpackage

// ==== dv/hpp_host_model.sv ====
// host processor model: masters the multiplexed 16-bit host pins
// assumes ready high holds the host off and ready low lets it finish
`timescale 1ns/10ps
module hpp_host_model
(
  input  wire logic        clock_i,
  input  wire logic        ready_i,
  input  wire logic [15:0] rdata_i,
  output logic             cs_n_o,
  output logic             ds_n_o,
  output logic             rw_o,
  output logic [1:0]       at_o,
  output logic             hw_o,
  output logic [15:0]      data_o
);
  // idle host: deselected, bus showing a filler pattern
  initial
  begin
    cs_n_o = 1'b1;
    ds_n_o = 1'b1;
    rw_o = 1'b1;
    at_o = 2'h0;
    hw_o = 1'b0;
    data_o = 16'h5A5A;
  end

  // one halfword; changes only after rising edges, as a master may
  task automatic half(input logic rw, input logic [1:0] at, input logic hw,
                      input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    q = 16'hXXXX;
    cs_n_o <= 1'b0;
    ds_n_o <= 1'b0;
    rw_o <= rw;
    at_o <= at;
    hw_o <= hw;
    data_o <= rw ? ~data_o : d;
    // wait for the hold-off, then for permission to finish
    do @(posedge clock_i); while (ready_i !== 1'b1 && ++n < 300);
    do @(posedge clock_i); while (ready_i !== 1'b0 && ++n < 600);
    if (n < 600)
      q = rdata_i;
    cs_n_o <= 1'b1;
    ds_n_o <= 1'b1;
    // write data is held past the synchronised strobe end
    repeat (3) @(posedge clock_i);
    data_o <= ~data_o;
    repeat (2) @(posedge clock_i);
  endtask

  // one full access: low half then high half
  task automatic word(input logic rw, input logic [1:0] at,
                      input logic [31:0] d, output logic [31:0] q);
    logic [15:0] lo;
    logic [15:0] hi;
    half(rw, at, 1'b0, d[15:0], lo);
    half(rw, at, 1'b1, d[31:16], hi);
    q = {hi, lo};
  endtask
endmodule

// ==== dv/tb_top.sv ====
// testbench for the host parallel port: host model, memory, wishbone cpu
// assumes the design answers wishbone one cycle after a request is taken
`timescale 1ns/10ps
`include "hpp_consts.svh"
module tb_top;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cs_n, ds_n, rw, hw;
  logic [1:0]  at;
  logic [15:0] hd_in, hd_out;
  logic        hd_oe, ready, host_int_n, cpu_int;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_q;
  logic        mem_req, mem_we, mem_ack = 1'b0;
  logic [31:0] mem_addr, mem_wdata, mem_rdata = 32'h0;
  logic [31:0] mem_q [0:15];
  int          mem_lat = 2, mem_cnt = 0, bad_count = 0, total_checks = 0;

  hpp_port dut_u (.clock_i(clock), .sys_rst_i(sys_rst), .host_cs_n_i(cs_n),
    .host_ds_n_i(ds_n), .host_rw_i(rw), .access_type_select_i(at),
    .halfword_select_i(hw), .host_data_i(hd_in), .host_data_o(hd_out),
    .host_data_oe_o(hd_oe), .port_ready_out_o(ready),
    .host_int_n_o(host_int_n), .cpu_int_o(cpu_int), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));

  hpp_host_model host_u (.clock_i(clock), .ready_i(ready), .rdata_i(hd_out),
    .cs_n_o(cs_n), .ds_n_o(ds_n), .rw_o(rw), .at_o(at), .hw_o(hw),
    .data_o(hd_in));

  // 200 MHz clock
  initial
  begin
    forever #2.5 clock = ~clock;
  end

  // memory: acks on the mem_lat+1th cycle a request is seen; read data garbles between acks
  always @(posedge clock)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      mem_cnt <= mem_cnt + 1;
      if (mem_cnt >= mem_lat)
      begin
        mem_ack <= 1'b1;
        mem_cnt <= 0;
        if (mem_we)
          mem_q[mem_addr[5:2]] <= mem_wdata;
        else
          mem_rdata <= mem_q[mem_addr[5:2]];
      end
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // classic wishbone single cycle; waits for ack, the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_dat <= d;
    do @(posedge clock); while (wb_ack !== 1'b1);
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    rd(`HPP_OFS_CTRL, q);
    chk("ctrl", 32'h0000_0030, q);
    rd(`HPP_OFS_CFG, q);
    chk("cfg", {16'h0000, `HPP_CFG_RST}, q);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, q);
    chk("unmapped", 32'h0, q);
    chk("host_int_n", 32'h1, {31'h0, host_int_n});
    host_u.word(1'b1, `HPP_AT_CTRL, 32'h0, q);
    chk("host ctrl", 32'h0000_0030, q);
    chk("oe idle", 32'h0, {31'h0, hd_oe});
    chk("rdy idle", 32'h0, {31'h0, ready});
  endtask

  // host loads a word-aligned address; single mode feeds both registers
  task automatic t_addr(input logic [31:0] a, input logic [31:0] ew,
                        input logic [31:0] er);
    logic [31:0] q;
    host_u.word(1'b0, `HPP_AT_ADDR, a, q);
    rd(`HPP_OFS_WADDR, q);
    chk("waddr", ew, q);
    rd(`HPP_OFS_RADDR, q);
    chk("raddr", er, q);
  endtask

  task automatic t_write();
    logic [31:0] q;
    int n;
    mem_lat = 6;
    t_addr(32'h0000_0040, 32'h0000_0040, 32'h0000_0040);
    host_u.word(1'b0, `HPP_AT_INC, 32'h1234_5678, q);
    host_u.word(1'b0, `HPP_AT_INC, 32'h9ABC_DEF0, q);
    n = 0;
    do rd(`HPP_OFS_CTRL, q); while (q[6:4] !== 3'h3 && ++n < 50);
    chk("drained", 32'h3, {29'h0, q[6:4]});
    chk("mem0", 32'h1234_5678, mem_q[0]);
    chk("mem1", 32'h9ABC_DEF0, mem_q[1]);
    rd(`HPP_OFS_WADDR, q);
    chk("waddr inc", 32'h0000_0048, q);
    rd(`HPP_OFS_RADDR, q);
    chk("raddr inc", 32'h0000_0048, q);
  endtask

  // slow memory: the host is held off until read data arrives
  task automatic t_read();
    logic [31:0] q;
    mem_lat = 12;
    t_addr(32'h0000_0044, 32'h0000_0044, 32'h0000_0044);
    host_u.word(1'b1, `HPP_AT_FIX, 32'h0, q);
    chk("fix rd", 32'h9ABC_DEF0, q);
    rd(`HPP_OFS_RADDR, q);
    chk("raddr fix", 32'h0000_0044, q);
    t_addr(32'h0000_0040, 32'h0000_0040, 32'h0000_0040);
    host_u.word(1'b1, `HPP_AT_INC, 32'h0, q);
    chk("inc rd0", 32'h1234_5678, q);
    host_u.word(1'b1, `HPP_AT_INC, 32'h0, q);
    chk("inc rd1", 32'h9ABC_DEF0, q);
  endtask

  // software prefetch fills the read fifo; an address load must wait for
  // the engine and must not be bumped by a read still in flight
  task automatic t_pref();
    logic [31:0] q;
    wr(`HPP_OFS_CFG, 32'h0000_0001);
    host_u.word(1'b1, `HPP_AT_INC, 32'h0, q);
    chk("pref rd0", 32'hC0DE_0002, q);
    host_u.word(1'b1, `HPP_AT_INC, 32'h0, q);
    chk("pref rd1", 32'hC0DE_0003, q);
    repeat (40) @(posedge clock);
    rd(`HPP_OFS_CTRL, q);
    chk("pref fill", 32'h0, {31'h0, q[`HPP_C_REMPTY]});
    t_addr(32'h0000_0040, 32'h0000_0040, 32'h0000_0040);
    wr(`HPP_OFS_CFG, 32'h0000_FF00);
  endtask

  // interrupts both ways, each set and cleared from the other side
  task automatic t_int();
    logic [31:0] q;
    wr(`HPP_OFS_CTRL, 32'h1);
    @(posedge clock);
    chk("host_int_n set", 32'h0, {31'h0, host_int_n});
    host_u.word(1'b0, `HPP_AT_CTRL, 32'h1, q);
    chk("host_int_n clr", 32'h1, {31'h0, host_int_n});
    host_u.word(1'b0, `HPP_AT_CTRL, 32'h2, q);
    chk("cpu_int set", 32'h1, {31'h0, cpu_int});
    wr(`HPP_OFS_CTRL, 32'h2);
    @(posedge clock);
    chk("cpu_int clr", 32'h0, {31'h0, cpu_int});
  endtask

  // dual mode steers host address writes; cpu lock refuses them
  task automatic t_dual_lock();
    logic [31:0] q;
    wr(`HPP_OFS_CTRL, 32'h4);
    t_addr(32'h0000_0100, 32'h0000_0100, 32'h0000_0040);
    wr(`HPP_OFS_CTRL, 32'hC);
    t_addr(32'h0000_0200, 32'h0000_0100, 32'h0000_0200);
    host_u.word(1'b1, `HPP_AT_ADDR, 32'h0, q);
    chk("host raddr", 32'h0000_0200, q);
    wr(`HPP_OFS_CTRL, 32'h0);
    wr(`HPP_OFS_CFG, 32'h0000_FF02);
    t_addr(32'h0000_0300, 32'h0000_0100, 32'h0000_0200);
    wr(`HPP_OFS_CFG, 32'h0000_FF00);
    wr(`HPP_OFS_WADDR, 32'h0000_0080);
    rd(`HPP_OFS_WADDR, q);
    chk("cpu waddr", 32'h0000_0080, q);
  endtask

  // a hang counts against the run
  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    for (int i = 0; i < 16; i++)
      mem_q[i] = 32'hC0DE_0000 | i;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_write();
    t_read();
    t_pref();
    t_int();
    t_dual_lock();
    end_sim();
  end
endmodule
